// *** shared/pm_pkg.sv ***
// power-mode controller constants: register map, field positions,
// reset values, timing and state type; no other package assumed.
package pm_pkg;
  localparam int DATA_W = 16;
  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_BASIC  = 5'h00;
  localparam logic [4:0] IDX_CTRL10 = 5'h10;
  localparam logic [4:0] IDX_CTRL11 = 5'h11;
  localparam logic [4:0] IDX_CTRL18 = 5'h18;
  localparam logic [4:0] IDX_STATUS = 5'h1E;
  localparam logic [4:0] IDX_CTRL1F = 5'h1F;
  // field positions
  localparam int BIT_SOFT_RESET  = 15;
  localparam int BIT_AN_ENABLE   = 12;
  localparam int BIT_POWER_DOWN  = 11;
  localparam int BIT_PLL_AUTOOFF = 4;
  localparam int BIT_SLOW_OSC    = 5;
  localparam int BIT_SLEEP_DIS_N = 11;
  localparam int BIT_LONG_PULSE  = 12;
  localparam int BIT_POWER_SAVE  = 10;
  // values after reset and writable bits
  localparam logic [15:0] BASIC_RST   = 16'h1000;
  localparam logic [15:0] CTRL10_RST  = 16'h0000;
  localparam logic [15:0] CTRL11_RST  = 16'h0000;
  localparam logic [15:0] CTRL18_RST  = 16'h0800;
  localparam logic [15:0] CTRL1F_RST  = 16'h0000;
  localparam logic [15:0] BASIC_WMASK  = 16'h9800;
  localparam logic [15:0] CTRL10_WMASK = 16'h0010;
  localparam logic [15:0] CTRL11_WMASK = 16'h0020;
  localparam logic [15:0] CTRL18_WMASK = 16'h1800;
  localparam logic [15:0] CTRL1F_WMASK = 16'h0400;
  // timing
  localparam int CLK_MHZ            = 50;
  localparam int SOFT_RESET_US      = 10;
  localparam int LINK_PULSE_US      = 16000;
  localparam int LINK_PULSE_LONG_US = 64000;
  localparam int SOFT_RESET_CYCLES  = SOFT_RESET_US * CLK_MHZ;
  localparam int LINK_PULSE_CYCLES  = LINK_PULSE_US * CLK_MHZ;
  localparam int LINK_LONG_CYCLES   = LINK_PULSE_LONG_US * CLK_MHZ;
  localparam int PULSE_CNT_W        = 24;
  localparam int RST_CNT_W          = 12;

  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_SAVING,
    ST_SLEEP,
    ST_POWER_DOWN,
    ST_LOWEST,
    ST_SOFT_RESET
  } pm_state_e;
endpackage

// *** rtl/link_pulse_timer.sv ***
// periodic link pulse generator used during cable-absent sleep
// assumes run and long_mode come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module link_pulse_timer #(
  parameter int CNT_W       = 24,
  parameter int SHORT_COUNT = 800000,
  parameter int LONG_COUNT  = 3200000
) (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // control
  input  wire logic run,
  input  wire logic long_mode,
  // pulse out
  output logic      pulse
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] limit;

  assign limit = long_mode ? CNT_W'(LONG_COUNT - 1) : CNT_W'(SHORT_COUNT - 1);

  // count resets whenever sleep ends so the first pulse is a full period away
  always_ff @(posedge clock) begin
    if (rst || !run || cnt_reg >= limit) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pulse <= 1'b0;
    end else begin
      pulse <= run && (cnt_reg >= limit);
    end
  end
endmodule // link_pulse_timer
`default_nettype wire

// *** rtl/phy_power_mode_control.sv ***
// power-mode controller: apb register slave, mode state machine,
// soft reset sequencer and block power enables.
// assumes link and energy pins are asynchronous; apb on clock.
// Functional notes
// - power-save enable is reg 1Fh bit 10
// - save only with autoneg on, no link
// - power-save enable resets to off
// - sleep enabled by zero at 18h bit 11
// - sleep enable bit resets to one
// - 10h bit 4 turns pll off asleep
// - sleep sends periodic link pulses, optional longer
// - 0h bit 11 powers down all but management
// - clearing 0h bit 11 leaves power-down
// - 11h bit 5 selects slow oscillator
// - slow osc plus power-down is lowest state
// - management clock at most 10 MHz; here the registers are on the 50 MHz clock (CLK_MHZ)
//
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ns
`default_nettype none
module phy_power_mode_control
  import pm_pkg::*;
#(
  parameter int SHORT_PULSE_CYCLES = pm_pkg::LINK_PULSE_CYCLES,
  parameter int LONG_PULSE_CYCLES  = pm_pkg::LINK_LONG_CYCLES
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // line status pins
  input  wire logic        link_up_pin,
  input  wire logic        energy_pin,
  // block power enables
  output logic             tx_on,
  output logic             rx_blocks_on,
  output logic             energy_det_on,
  output logic             pll_on,
  output logic             ref_clock_input_on,
  output logic             slow_osc_sel,
  output logic             link_pulse,
  output logic             core_rst
);
  import pm_pkg::*;

  logic [15:0] basic_reg;
  logic [15:0] ctrl10_reg;
  logic [15:0] ctrl11_reg;
  logic [15:0] ctrl18_reg;
  logic [15:0] ctrl1f_reg;
  logic [RST_CNT_W-1:0] rst_cnt_reg;
  logic [1:0]  sync1_reg;
  logic [1:0]  sync2_reg;
  pm_state_e   state_reg;
  pm_state_e   state_next;

  logic [4:0]  idx;
  logic        addr_ok;
  logic        mapped;
  logic        wr_en;
  logic [15:0] lane_mask;
  logic [15:0] wdata;
  logic [15:0] rd_mux;
  logic [15:0] status_word;
  logic        reset_busy;
  logic        reset_done;
  logic        link_up;
  logic        energy;
  logic        an_enable;
  logic        no_link_an;
  logic        sleep_run;

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] val,
                                        input logic [15:0] m);
    merge = (old & ~m) | (val & m);
  endfunction

  // apb decode; word aligned, 16-bit registers in the low lanes
  assign idx       = paddr[6:2];
  assign addr_ok   = (paddr[1:0] == 2'h0) && (paddr[11:7] == 5'h00);
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wdata     = pwdata[15:0];

  always_comb begin
    mapped = 1'b0;
    rd_mux = 16'h0000;
    if (addr_ok) begin
      case (idx)
        IDX_BASIC: begin
          mapped = 1'b1;
          rd_mux = basic_reg;
        end
        IDX_CTRL10: begin
          mapped = 1'b1;
          rd_mux = ctrl10_reg;
        end
        IDX_CTRL11: begin
          mapped = 1'b1;
          rd_mux = ctrl11_reg;
        end
        IDX_CTRL18: begin
          mapped = 1'b1;
          rd_mux = ctrl18_reg;
        end
        IDX_STATUS: begin
          mapped = 1'b1;
          rd_mux = status_word;
        end
        IDX_CTRL1F: begin
          mapped = 1'b1;
          rd_mux = ctrl1f_reg;
        end
        default: begin
          mapped = 1'b0;
          rd_mux = 16'h0000;
        end
      endcase
    end
  end

  // slave answers in the first access cycle; bus never gated by mode
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && mapped;

  // read data captured in the setup cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= {16'h0000, rd_mux};
    end
  end

  // soft reset sequencer
  assign reset_busy = basic_reg[BIT_SOFT_RESET];
  assign reset_done = reset_busy &&
                      (rst_cnt_reg == RST_CNT_W'(SOFT_RESET_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (rst || !reset_busy) begin
      rst_cnt_reg <= '0;
    end else begin
      rst_cnt_reg <= rst_cnt_reg + RST_CNT_W'(1);
    end
  end

  // basic control; a write in the finishing cycle wins over the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      basic_reg <= BASIC_RST;
    end else if (wr_en && idx == IDX_BASIC) begin
      basic_reg <= merge(basic_reg, wdata, lane_mask & BASIC_WMASK);
    end else if (reset_done) begin
      basic_reg <= BASIC_RST;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl10_reg <= CTRL10_RST;
    end else if (wr_en && idx == IDX_CTRL10) begin
      ctrl10_reg <= merge(ctrl10_reg, wdata, lane_mask & CTRL10_WMASK);
    end else if (reset_done) begin
      ctrl10_reg <= CTRL10_RST;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl11_reg <= CTRL11_RST;
    end else if (wr_en && idx == IDX_CTRL11) begin
      ctrl11_reg <= merge(ctrl11_reg, wdata, lane_mask & CTRL11_WMASK);
    end else if (reset_done) begin
      ctrl11_reg <= CTRL11_RST;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl18_reg <= CTRL18_RST;
    end else if (wr_en && idx == IDX_CTRL18) begin
      ctrl18_reg <= merge(ctrl18_reg, wdata, lane_mask & CTRL18_WMASK);
    end else if (reset_done) begin
      ctrl18_reg <= CTRL18_RST;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl1f_reg <= CTRL1F_RST;
    end else if (wr_en && idx == IDX_CTRL1F) begin
      ctrl1f_reg <= merge(ctrl1f_reg, wdata, lane_mask & CTRL1F_WMASK);
    end else if (reset_done) begin
      ctrl1f_reg <= CTRL1F_RST;
    end
  end

  // line status pins through two flops
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_reg <= 2'h0;
      sync2_reg <= 2'h0;
    end else begin
      sync1_reg <= {energy_pin, link_up_pin};
      sync2_reg <= sync1_reg;
    end
  end

  assign link_up    = sync2_reg[0];
  assign energy     = sync2_reg[1];
  assign an_enable  = basic_reg[BIT_AN_ENABLE];
  assign no_link_an = an_enable && !link_up;

  // mode selection, highest priority first
  always_comb begin
    if (reset_busy) begin
      state_next = ST_SOFT_RESET;
    end else if (basic_reg[BIT_POWER_DOWN] && ctrl11_reg[BIT_SLOW_OSC]) begin
      state_next = ST_LOWEST;
    end else if (basic_reg[BIT_POWER_DOWN]) begin
      state_next = ST_POWER_DOWN;
    end else if (!ctrl18_reg[BIT_SLEEP_DIS_N] && no_link_an && !energy) begin
      state_next = ST_SLEEP;
    end else if (ctrl1f_reg[BIT_POWER_SAVE] && no_link_an) begin
      state_next = ST_SAVING;
    end else begin
      state_next = ST_NORMAL;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= ST_NORMAL;
    end else begin
      state_reg <= state_next;
    end
  end

  // block enables follow the chosen mode
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_on         <= 1'b1;
      rx_blocks_on  <= 1'b1;
      energy_det_on <= 1'b1;
      pll_on        <= 1'b1;
    end else begin
      case (state_next)
        ST_NORMAL, ST_SOFT_RESET: begin
          tx_on         <= 1'b1;
          rx_blocks_on  <= 1'b1;
          energy_det_on <= 1'b1;
          pll_on        <= 1'b1;
        end
        ST_SAVING: begin
          tx_on         <= 1'b1;
          rx_blocks_on  <= 1'b0;
          energy_det_on <= 1'b1;
          pll_on        <= 1'b1;
        end
        ST_SLEEP: begin
          tx_on         <= 1'b1;
          rx_blocks_on  <= 1'b0;
          energy_det_on <= 1'b1;
          pll_on        <= !ctrl10_reg[BIT_PLL_AUTOOFF];
        end
        ST_POWER_DOWN, ST_LOWEST: begin
          tx_on         <= 1'b0;
          rx_blocks_on  <= 1'b0;
          energy_det_on <= 1'b0;
          pll_on        <= 1'b0;
        end
        default: begin
          tx_on         <= 1'b1;
          rx_blocks_on  <= 1'b1;
          energy_det_on <= 1'b1;
          pll_on        <= 1'b1;
        end
      endcase
    end
  end

  // oscillator selection is independent of the power-down state
  always_ff @(posedge clock) begin
    if (rst) begin
      slow_osc_sel       <= 1'b0;
      ref_clock_input_on <= 1'b1;
    end else begin
      slow_osc_sel       <= ctrl11_reg[BIT_SLOW_OSC];
      ref_clock_input_on <= !ctrl11_reg[BIT_SLOW_OSC];
    end
  end

  // core held in reset while the soft reset runs
  always_ff @(posedge clock) begin
    if (rst) begin
      core_rst <= 1'b1;
    end else begin
      core_rst <= reset_busy;
    end
  end

  // next state keeps pulses aligned with the registered block enables
  assign sleep_run = (state_next == ST_SLEEP);

  link_pulse_timer #(
    .CNT_W       (PULSE_CNT_W),
    .SHORT_COUNT (SHORT_PULSE_CYCLES),
    .LONG_COUNT  (LONG_PULSE_CYCLES)
  ) u_pulse (
    .clock     (clock),
    .rst       (rst),
    .run       (sleep_run),
    .long_mode (ctrl18_reg[BIT_LONG_PULSE]),
    .pulse     (link_pulse)
  );

  // status: [0] link [1] energy [2] saving [3] sleep
  // [4] power-down [5] lowest [6] reset busy
  assign status_word = {9'h000,
                        reset_busy,
                        state_reg == ST_LOWEST,
                        state_reg == ST_POWER_DOWN,
                        state_reg == ST_SLEEP,
                        state_reg == ST_SAVING,
                        energy,
                        link_up};
endmodule // phy_power_mode_control
`default_nettype wire

// *** test/pm_props.sv ***
// checker on the power-mode controller top ports
// assumes zero-wait apb on clock and a 500-cycle soft reset
`timescale 1ns/1ns
`default_nettype none
module pm_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // apb
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  // enables
  input wire logic        tx_on,
  input wire logic        rx_blocks_on,
  input wire logic        energy_det_on,
  input wire logic        pll_on,
  input wire logic        ref_clock_input_on,
  input wire logic        slow_osc_sel,
  input wire logic        link_pulse,
  input wire logic        core_rst
);
  logic [9:0] busy_cnt;
  logic       wr_acc;
  assign wr_acc = psel && penable && pwrite && !core_rst;
  // sampled cycles of soft reset
  always_ff @(posedge clock) begin
    if (rst || !core_rst) busy_cnt <= 10'h000;
    else busy_cnt <= busy_cnt + 10'h001;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  a_zero_wait: assert property (psel |-> pready)
    else $error("pready low");
  a_err_unmapped: assert property (psel && penable && paddr == 12'h008 |-> pslverr)
    else $error("no error on unmapped address");
  a_err_setup: assert property (psel && !penable |-> !pslverr)
    else $error("error outside access phase");
  a_pd_all_off: assert property (wr_acc && paddr == 12'h000 && pstrb[1]
    && pwdata[11] && !pwdata[15] |-> ##2 !tx_on && !rx_blocks_on && !energy_det_on && !pll_on)
    else $error("power-down left a block on");
  a_osc_switch: assert property (wr_acc && paddr == 12'h044 && pstrb[0] && pwdata[5]
    |-> ##2 slow_osc_sel && !ref_clock_input_on)
    else $error("slow oscillator not selected");
  a_osc_pair: assert property (slow_osc_sel |-> !ref_clock_input_on)
    else $error("reference clock still connected");
  a_pulse_single: assert property (link_pulse |=> !link_pulse)
    else $error("link pulse longer than one cycle");
  a_pulse_asleep: assert property (link_pulse |-> tx_on && energy_det_on && !rx_blocks_on)
    else $error("link pulse outside sleep");
  a_soft_start: assert property (wr_acc && paddr == 12'h000 && pstrb[1] && pwdata[15]
    |-> ##2 core_rst)
    else $error("soft reset not started");
  a_soft_len: assert property ($fell(core_rst) && busy_cnt > 10'h002 |-> busy_cnt == 10'h1F4)
    else $error("soft reset length wrong");
  c_sleep_pulse: cover property (link_pulse);
  c_lowest: cover property (slow_osc_sel && !tx_on);
  c_soft_done: cover property ($fell(core_rst) && busy_cnt > 10'h002);
endmodule // pm_props
`default_nettype wire

// *** test/apb_host.sv ***
// host model: apb master for the power-mode registers
// assumes the slave shares clock; waits on pready
`timescale 1ns/1ns
`default_nettype none
module apb_host (
  // clock
  input  wire logic        clock,
  // apb master
  output logic [11:0]      paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    paddr   = 12'hFFF;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0;
    pstrb   = 4'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb  <= s;
    @(posedge clock);
    penable <= 1'b1;
    // loops until pready is high; only the bench timeout ends a stuck wait
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // released bus shows no stale request
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule // apb_host
`default_nettype wire

// *** test/phy_power_mode_control_tb.sv ***
// testbench for the power-mode controller with a register model
// assumes pm_pkg, apb_host and pm_props are compiled first
`timescale 1ns/1ns
`default_nettype none
module phy_power_mode_control_tb;
  import pm_pkg::*;
  logic        clock, rst, link_up_pin, energy_pin, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lfsr_state;
  logic [3:0]  pstrb;
  logic        tx_on, rx_blocks_on, energy_det_on, pll_on;
  logic        ref_clock_input_on, slow_osc_sel, link_pulse, core_rst;
  logic [15:0] mdl [32];
  logic [4:0]  idx_list [5] = '{5'h00, 5'h10, 5'h11, 5'h18, 5'h1F};
  int          miscompares, n_checks, cycles;
  phy_power_mode_control #(.SHORT_PULSE_CYCLES(20), .LONG_PULSE_CYCLES(40)) i_dut (
    .clock, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready,
    .pslverr, .link_up_pin, .energy_pin, .tx_on, .rx_blocks_on, .energy_det_on, .pll_on,
    .ref_clock_input_on, .slow_osc_sel, .link_pulse, .core_rst);
  apb_host i_host (.clock, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr);
  initial clock = 1'b0;
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] wmask(input logic [4:0] idx);
    case (idx)
      IDX_BASIC:  return BASIC_WMASK;
      IDX_CTRL10: return CTRL10_WMASK;
      IDX_CTRL11: return CTRL11_WMASK;
      IDX_CTRL18: return CTRL18_WMASK;
      IDX_CTRL1F: return CTRL1F_WMASK;
      default:    return 16'h0000;
    endcase
  endfunction
  // expected {tx, rx, energy det, pll, ref clock, slow osc}
  function automatic logic [5:0] exp_en();
    logic an, osc;
    an  = mdl[0][BIT_AN_ENABLE];
    osc = mdl[17][BIT_SLOW_OSC];
    if (mdl[0][BIT_POWER_DOWN]) return {4'h0, !osc, osc};
    if (!mdl[24][BIT_SLEEP_DIS_N] && an && !link_up_pin && !energy_pin)
      return {3'b101, !mdl[16][BIT_PLL_AUTOOFF], !osc, osc};
    if (mdl[31][BIT_POWER_SAVE] && an && !link_up_pin) return {4'hB, !osc, osc};
    return {4'hF, !osc, osc};
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic settle();
    logic [5:0] seen;
    @(posedge clock);
    #1;
    seen = {tx_on, rx_blocks_on, energy_det_on, pll_on, ref_clock_input_on, slow_osc_sel};
    chk("enables", {26'h0, seen}, {26'h0, exp_en()});
  endtask
  task automatic wr(input logic [4:0] idx, input logic [15:0] v);
    logic [31:0] d;
    logic        err;
    lfsr_state = lfsr_next(lfsr_state);
    mdl[idx] = (mdl[idx] & ~wmask(idx)) | (v & wmask(idx));
    i_host.xfer(1'b1, {5'h00, idx, 2'b00}, {lfsr_state[31:16], v}, {lfsr_state[3:2], 2'b11}, d, err);
    settle();
  endtask
  task automatic rd(input logic [11:0] a, input logic [15:0] exp, input logic exp_err);
    logic [31:0] d;
    logic        err;
    i_host.xfer(1'b0, a, 32'h0, 4'h0, d, err);
    chk("read data", d, {16'h0000, exp});
    chk("slave error", {31'h0, err}, {31'h0, exp_err});
  endtask
  task automatic reset_model();
    foreach (mdl[i]) mdl[i] = 16'h0000;
    mdl[0]  = BASIC_RST;
    mdl[24] = CTRL18_RST;
  endtask
  task automatic check_all();
    foreach (idx_list[i]) rd({5'h00, idx_list[i], 2'b00}, mdl[idx_list[i]], 1'b0);
  endtask
  task automatic set_pins(input logic l, input logic e);
    @(posedge clock);
    link_up_pin <= l;
    energy_pin  <= e;
    repeat (3) @(posedge clock);
    settle();
  endtask
  task automatic count_pulses(input int span, input int exp);
    int n;
    n = 0;
    repeat (span) begin
      @(posedge clock);
      #1;
      if (link_pulse === 1'b1) n++;
    end
    chk("link pulses", n, exp);
  endtask
  initial begin
    rst = 1'b1;
    link_up_pin = 1'b0;
    energy_pin = 1'b0;
    lfsr_state = 32'h5FF0;
    miscompares = 0;
    n_checks = 0;
    cycles = 0;
    reset_model();
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    check_all();
    rd(12'h008, 16'h0000, 1'b1);
    wr(5'h1F, 16'h0400);
    wr(5'h10, 16'h0010);
    wr(5'h18, 16'h0000);
    count_pulses(50, 2);
    wr(5'h18, 16'h1000);
    count_pulses(90, 2);
    set_pins(1'b0, 1'b1);
    wr(5'h00, 16'h0000);
    wr(5'h00, 16'h1000);
    set_pins(1'b1, 1'b0);
    wr(5'h00, 16'h1800);
    wr(5'h11, 16'h0020);
    rd(12'h044, 16'h0020, 1'b0);
    rd(12'h078, 16'h0021, 1'b0);
    wr(5'h11, 16'h0000);
    wr(5'h00, 16'h1000);
    wr(5'h00, 16'h9000);
    repeat (505) @(posedge clock);
    #1;
    chk("soft reset busy", {31'h0, core_rst}, 32'h0);
    reset_model();
    check_all();
    wrap_up();
  end
endmodule // phy_power_mode_control_tb
bind phy_power_mode_control pm_props i_props (.clock, .rst, .paddr, .psel, .penable, .pwrite,
  .pwdata, .pstrb, .pready, .pslverr, .tx_on, .rx_blocks_on, .energy_det_on, .pll_on,
  .ref_clock_input_on, .slow_osc_sel, .link_pulse, .core_rst);
`default_nettype wire
